// *** hdl/mce_core.sv ***
// motion command interpreter: control commands, events, user functions
`timescale 1ns/1ns
// Summary of operation
// - event request: immediate reply, later reached reply
// - event request only from direct host operation
// - event value is per-motor mask, bit n
// - type 0: notify only next move command
// - type 1: notify every later move command
// - immediate reply: status 100, command 138, mask
// - reached reply: status 128, command 138, mask
// - control commands only from host, never program
// - 128 halts the running program
// - 129 runs, type 1 from given address
// - 130 executes one instruction then pauses
// - 131 stops, zeroes counters, registers, flags
// - 132 enters download at given address
// - 133 leaves download mode
// - 134 returns one program memory word
// - 135 reports status chosen by type
// - 136 returns version, text or binary
// - 137 with 1234 restores defaults, no reply
// - 255 with 1234 restarts the processor
// - user functions answer status 100, user value, outside download
module mce_core import mce_pkg::*; #(
    parameter int NMOT = 8,
    parameter int DEPTH = 64,
    parameter int PCW = 16,
    parameter logic [7:0] MOVE_OPCODE = 8'h04,
    // version codes, values are arbitrary
    parameter logic [31:0] FW_BINARY = 32'h00000101,
    parameter logic [31:0] FW_TEXT = 32'h56313031
) (
    input wire logic CLK_SYS_IN,
    input wire logic RST_IN,
    input wire logic CMD_VALID_IN,
    input wire mce_cmd_t CMD_IN,
    input wire logic CMD_FROM_PROG_IN,
    input wire logic [NMOT-1:0] MOTOR_REACHED_IN,
    input wire logic PROG_ADV_IN,
    input wire logic PROG_WAIT_IN,
    input wire logic [3:0] ADDR_IN,
    input wire logic [31:0] WR_DATA_IN,
    input wire logic WR_EN_IN,
    input wire logic RD_EN_IN,
    output logic [31:0] RD_DATA_OUT,
    output logic REPLY_VALID_OUT,
    output mce_reply_t REPLY_OUT,
    output mce_prog_state_t PROG_MODE_OUT,
    output logic [PCW-1:0] PROG_PC_OUT,
    output logic DL_MODE_OUT,
    output logic PROG_CLEAR_OUT,
    output logic FACTORY_OUT,
    output logic SWRESET_OUT,
    output logic [31:0] ACCU_OUT,
    output logic [31:0] XREG_OUT
);
    localparam int AW = $clog2(DEPTH);
    mce_prog_state_t state_q;
    logic [PCW-1:0] pc_q;
    logic [AW-1:0] ptr_q;
    logic [31:0] accu_q, xreg_q, flags_q, user_q, rd_q;
    logic dl_q, armed_q, persist_q, clr_q, fac_q, swr_q;
    logic [NMOT-1:0] mask_q, watch_q, pend_q, hit;
    logic [7:0] op;
    logic direct, is_ctrl, is_uf, ctrl_go, evt_go, dl_store, mvp_go, magic;
    logic req_v, evt_send;
    mce_req_t req;
    mce_cmd_t mem_rd;
    mce_app_stat_t app_stat;
    mce_status_reg_t stat_reg;
    mce_notify_reg_t notif_reg;
    // command classification; motor byte is never looked at
    assign op = CMD_IN.opcode;
    assign direct = !CMD_FROM_PROG_IN;
    assign is_ctrl = (op >= OP_STOP && op <= OP_FACTORY)
                  || op == OP_SWRESET;
    assign is_uf = op >= OP_UF_FIRST && op <= OP_UF_LAST;
    assign magic = CMD_IN.value == MAGIC_KEY;
    // control only from the host, program copies dropped
    assign ctrl_go = CMD_VALID_IN && direct && is_ctrl;
    // event request ignored when it comes from a program
    assign evt_go = CMD_VALID_IN && direct && op == OP_EVENT;
    // in download, ordinary host commands are stored
    assign dl_store = CMD_VALID_IN && direct && dl_q && !is_ctrl
                   && op != OP_EVENT;
    // move commands executed by program, or by host outside download
    assign mvp_go = CMD_VALID_IN && op == MOVE_OPCODE
                 && !(direct && dl_q);
    // motors watched that just arrived
    assign hit = watch_q & MOTOR_REACHED_IN;
    // program run state
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            state_q <= PS_STOP;
        end else if (ctrl_go && (op == OP_STOP || op == OP_RESET)) begin
            state_q <= PS_STOP;
        end else if (ctrl_go && op == OP_RUN) begin
            state_q <= PS_RUN;
        end else if (ctrl_go && op == OP_STEP) begin
            state_q <= PS_STEP;
        end else if (PROG_ADV_IN && state_q == PS_STEP) begin
            state_q <= PS_STOP;
        end
    end
    // program counter
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            pc_q <= '0;
        end else if (ctrl_go && op == OP_RESET) begin
            pc_q <= '0;
        end else if (ctrl_go && op == OP_RUN && CMD_IN.ctype == TYPE_1) begin
            pc_q <= CMD_IN.value[PCW-1:0];
        end else if (PROG_ADV_IN && state_q != PS_STOP) begin
            pc_q <= pc_q + 1'b1;
        end
    end
    // download mode and write index
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            dl_q <= 1'b0;
            ptr_q <= '0;
        end else if (ctrl_go && op == OP_DL_ENTER) begin
            dl_q <= 1'b1;
            ptr_q <= CMD_IN.value[AW-1:0];
        end else if (ctrl_go && op == OP_DL_EXIT) begin
            dl_q <= 1'b0;
        end else if (dl_store) begin
            ptr_q <= ptr_q + 1'b1;
        end
    end
    // accumulator, index register, flags; bus write beats clearing
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            accu_q <= '0;
            xreg_q <= '0;
            flags_q <= '0;
            user_q <= '0;
        end else begin
            if (ctrl_go && op == OP_RESET) begin
                accu_q <= '0;
                xreg_q <= '0;
                flags_q <= '0;
            end
            if (WR_EN_IN && ADDR_IN == REG_ACCU) begin
                accu_q <= WR_DATA_IN;
            end
            if (WR_EN_IN && ADDR_IN == REG_XREG) begin
                xreg_q <= WR_DATA_IN;
            end
            if (WR_EN_IN && ADDR_IN == REG_FLAGS) begin
                flags_q <= WR_DATA_IN;
            end
            if (WR_EN_IN && ADDR_IN == REG_USER) begin
                user_q <= WR_DATA_IN;
            end
        end
    end
    // event arming from the request mask
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            armed_q <= 1'b0;
            persist_q <= 1'b0;
            mask_q <= '0;
        end else if (evt_go) begin
            armed_q <= 1'b1;
            persist_q <= CMD_IN.ctype == TYPE_1;
            mask_q <= CMD_IN.value[NMOT-1:0];
        end else if (mvp_go && armed_q && !persist_q) begin
            armed_q <= 1'b0;
        end
    end
    // watched motors and unreported arrivals; setting beats clearing
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            watch_q <= '0;
            pend_q <= '0;
        end else begin
            watch_q <= (watch_q & ~hit)
                     | ((mvp_go && armed_q) ? mask_q : '0);
            pend_q <= (pend_q & ~(evt_send ? pend_q : '0)) | hit;
        end
    end
    // one-cycle side-effect pulses
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            clr_q <= 1'b0;
            fac_q <= 1'b0;
            swr_q <= 1'b0;
        end else begin
            clr_q <= ctrl_go && op == OP_RESET;
            fac_q <= ctrl_go && op == OP_FACTORY && magic;
            swr_q <= ctrl_go && op == OP_SWRESET && magic;
        end
    end

    mce_prog_mem #(
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_mem (
        .clk_in(CLK_SYS_IN),
        .wr_en_in(dl_store),
        .wr_addr_in(ptr_q),
        .wr_data_in(CMD_IN),
        .rd_addr_in(CMD_IN.value[AW-1:0]),
        .rd_data_out(mem_rd)
    );
    // status word for command 135, types 0 and 1
    always_comb begin
        app_stat.mode = {5'h00, dl_q, state_q};
        app_stat.wait_b = {7'h00, PROG_WAIT_IN};
        app_stat.ptr = (CMD_IN.ctype == TYPE_0) ? 16'(ptr_q) : 16'(pc_q);
    end
    // reply request: command answer first, reached report otherwise
    always_comb begin
        req_v = 1'b0;
        evt_send = 1'b0;
        req.status = STAT_OK;
        req.command = op;
        req.value = '0;
        if (evt_go) begin
            req_v = 1'b1;
            req.value = {24'h000000, CMD_IN.value[7:0]};
        end else if (CMD_VALID_IN && direct && is_uf && !dl_q) begin
            req_v = 1'b1;
            req.value = user_q;
        end else if (dl_store) begin
            req_v = 1'b1;
        end else if (ctrl_go) begin
            req_v = op != OP_FACTORY
                 && (op != OP_SWRESET || magic);
            if (op == OP_READ_MEM) begin
                req.command = mem_rd.opcode;
                req.value = mem_rd.value;
            end else if (op == OP_STATUS) begin
                if (CMD_IN.ctype == TYPE_0 || CMD_IN.ctype == TYPE_1) begin
                    req.value = app_stat;
                end else if (CMD_IN.ctype == TYPE_2) begin
                    req.value = accu_q;
                end else if (CMD_IN.ctype == TYPE_3) begin
                    req.value = xreg_q;
                end
            end else if (op == OP_VERSION) begin
                req.value = (CMD_IN.ctype == TYPE_0) ? FW_TEXT
                                                   : FW_BINARY;
            end
        end
        if (!req_v && pend_q != '0) begin
            req_v = 1'b1;
            evt_send = 1'b1;
            req.status = STAT_REACHED;
            req.command = OP_EVENT;
            req.value = 32'(pend_q);
        end
    end

    mce_reply u_reply (
        .clk_in(CLK_SYS_IN),
        .rst_in(RST_IN),
        .req_valid_in(req_v),
        .req_in(req),
        .valid_out(REPLY_VALID_OUT),
        .reply_out(REPLY_OUT)
    );
    // register read views
    always_comb begin
        stat_reg = '0;
        stat_reg.mode = state_q;
        stat_reg.dl = dl_q;
        stat_reg.wait_f = PROG_WAIT_IN;
        stat_reg.ptr = 16'(ptr_q);
        notif_reg = '0;
        notif_reg.persist = persist_q;
        notif_reg.armed = armed_q;
        notif_reg.pend = 8'(pend_q);
        notif_reg.mask = 8'(mask_q);
    end
    // read data in the cycle after the strobe only
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN || !RD_EN_IN) begin
            rd_q <= '0;
        end else begin
            unique case (ADDR_IN)
                REG_STATUS: rd_q <= stat_reg;
                REG_PC: rd_q <= 32'(pc_q);
                REG_ACCU: rd_q <= accu_q;
                REG_XREG: rd_q <= xreg_q;
                REG_FLAGS: rd_q <= flags_q;
                REG_USER: rd_q <= user_q;
                REG_NOTIFY: rd_q <= notif_reg;
                default: rd_q <= '0;
            endcase
        end
    end

    assign RD_DATA_OUT = rd_q;
    assign PROG_MODE_OUT = state_q;
    assign PROG_PC_OUT = pc_q;
    assign DL_MODE_OUT = dl_q;
    assign PROG_CLEAR_OUT = clr_q;
    assign FACTORY_OUT = fac_q;
    assign SWRESET_OUT = swr_q;
    assign ACCU_OUT = accu_q;
    assign XREG_OUT = xreg_q;
    // checks
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (RST_IN);
    sequence host_cmd(logic [7:0] code);
        CMD_VALID_IN && direct && op == code;
    endsequence
    sequence step_then_adv;
        host_cmd(OP_STEP) ##1 (!CMD_VALID_IN && !PROG_ADV_IN)
            ##1 (PROG_ADV_IN && !CMD_VALID_IN);
    endsequence
    event_ack_a: assert property (
        host_cmd(OP_EVENT) |=> REPLY_VALID_OUT
            && REPLY_OUT.status == STAT_OK
            && REPLY_OUT.command == OP_EVENT
            && REPLY_OUT.value[31:8] == 24'h000000)
        else $error("event request not answered with status 100");
    prog_event_a: assert property (
        (CMD_VALID_IN && !direct && op == OP_EVENT && !mvp_go)
            |=> $stable(mask_q) && $stable(armed_q))
        else $error("event request from program changed arming");
    reached_fmt_a: assert property (
        REPLY_VALID_OUT && REPLY_OUT.status == STAT_REACHED
            |-> REPLY_OUT.command == OP_EVENT
            && REPLY_OUT.value[31:8] == 24'h000000)
        else $error("reached reply has bad layout");
    single_shot_a: assert property (
        (mvp_go && armed_q && !persist_q && !evt_go) |=> !armed_q)
        else $error("single notification did not disarm");
    persist_arm_a: assert property (
        (mvp_go && armed_q && persist_q && !evt_go) |=> armed_q)
        else $error("persistent notification disarmed");
    stop_app_a: assert property (
        host_cmd(OP_STOP) |=> PROG_MODE_OUT == PS_STOP)
        else $error("stop command left program running");
    step_pause_a: assert property (
        step_then_adv |=> PROG_MODE_OUT == PS_STOP)
        else $error("step did not pause after one instruction");
    reset_app_a: assert property (
        host_cmd(OP_RESET) ##0 !WR_EN_IN |=> PROG_PC_OUT == '0
            && ACCU_OUT == '0 && XREG_OUT == '0 && flags_q == '0
            && PROG_CLEAR_OUT)
        else $error("reset command did not clear program state");
    dl_enter_a: assert property (
        host_cmd(OP_DL_ENTER)
            |=> DL_MODE_OUT && ptr_q == $past(CMD_IN.value[AW-1:0]))
        else $error("download entry wrong");
    factory_a: assert property (
        host_cmd(OP_FACTORY) ##0 magic |=> FACTORY_OUT
            && !(REPLY_VALID_OUT && REPLY_OUT.status == STAT_OK))
        else $error("factory restore misbehaved");
    csum_a: assert property (
        REPLY_VALID_OUT |-> REPLY_OUT.csum == 8'(REPLY_OUT.tgt
            + REPLY_OUT.host + REPLY_OUT.status + REPLY_OUT.command
            + REPLY_OUT.value[31:24] + REPLY_OUT.value[23:16]
            + REPLY_OUT.value[15:8] + REPLY_OUT.value[7:0]))
        else $error("reply checksum wrong");
endmodule

// *** hdl/mce_pkg.sv ***
// shared constants, command/reply carriers and register layouts
package mce_pkg;
    // control opcodes, only taken from the host in direct operation
    localparam logic [7:0] OP_STOP = 8'h80;
    localparam logic [7:0] OP_RUN = 8'h81;
    localparam logic [7:0] OP_STEP = 8'h82;
    localparam logic [7:0] OP_RESET = 8'h83;
    localparam logic [7:0] OP_DL_ENTER = 8'h84;
    localparam logic [7:0] OP_DL_EXIT = 8'h85;
    localparam logic [7:0] OP_READ_MEM = 8'h86;
    localparam logic [7:0] OP_STATUS = 8'h87;
    localparam logic [7:0] OP_VERSION = 8'h88;
    localparam logic [7:0] OP_FACTORY = 8'h89;
    localparam logic [7:0] OP_SWRESET = 8'hFF;
    // position-reached event request
    localparam logic [7:0] OP_EVENT = 8'h8A;
    // user function opcode range
    localparam logic [7:0] OP_UF_FIRST = 8'h40;
    localparam logic [7:0] OP_UF_LAST = 8'h47;
    // reply header and status codes
    localparam logic [7:0] REPLY_TGT = 8'h01;
    localparam logic [7:0] REPLY_HOST = 8'h02;
    localparam logic [7:0] STAT_OK = 8'h64;
    localparam logic [7:0] STAT_REACHED = 8'h80;
    // guard value for destructive commands
    localparam logic [31:0] MAGIC_KEY = 32'h000004D2;
    // type field codes
    localparam logic [7:0] TYPE_0 = 8'h00;
    localparam logic [7:0] TYPE_1 = 8'h01;
    localparam logic [7:0] TYPE_2 = 8'h02;
    localparam logic [7:0] TYPE_3 = 8'h03;
    // register word addresses
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_PC = 4'h1;
    localparam logic [3:0] REG_ACCU = 4'h2;
    localparam logic [3:0] REG_XREG = 4'h3;
    localparam logic [3:0] REG_FLAGS = 4'h4;
    localparam logic [3:0] REG_USER = 4'h5;
    localparam logic [3:0] REG_NOTIFY = 4'h6;

    typedef enum logic [1:0] {
        PS_STOP = 2'b00,
        PS_RUN = 2'b01,
        PS_STEP = 2'b10
    } mce_prog_state_t;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] ctype;
        logic [7:0] motor;
        logic [31:0] value;
    } mce_cmd_t;

    typedef struct packed {
        logic [7:0] status;
        logic [7:0] command;
        logic [31:0] value;
    } mce_req_t;

    typedef struct packed {
        logic [7:0] tgt;
        logic [7:0] host;
        logic [7:0] status;
        logic [7:0] command;
        logic [31:0] value;
        logic [7:0] csum;
    } mce_reply_t;

    typedef struct packed {
        logic [15:0] ptr;
        logic [11:0] rsv;
        logic wait_f;
        logic dl;
        logic [1:0] mode;
    } mce_status_reg_t;

    typedef struct packed {
        logic [13:0] rsv;
        logic persist;
        logic armed;
        logic [7:0] pend;
        logic [7:0] mask;
    } mce_notify_reg_t;

    typedef struct packed {
        logic [15:0] ptr;
        logic [7:0] wait_b;
        logic [7:0] mode;
    } mce_app_stat_t;
endpackage

// *** hdl/mce_prog_mem.sv ***
// program memory held in flip-flops, one write port, one read port
`timescale 1ns/1ns
module mce_prog_mem import mce_pkg::*; #(
    parameter int DEPTH = 64,
    parameter int AW = 6
) (
    input wire logic clk_in,
    input wire logic wr_en_in,
    input wire logic [AW-1:0] wr_addr_in,
    input wire mce_cmd_t wr_data_in,
    input wire logic [AW-1:0] rd_addr_in,
    output mce_cmd_t rd_data_out
);
    mce_cmd_t mem_q [DEPTH];

    // downloaded instructions land at the write index
    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem_q[wr_addr_in] <= wr_data_in;
        end
    end

    // read by index, no latency
    assign rd_data_out = mem_q[rd_addr_in];
endmodule

// *** hdl/mce_reply.sv ***
// reply frame builder: header, fields and checksum, registered
`timescale 1ns/1ns
module mce_reply import mce_pkg::*; (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic req_valid_in,
    input wire mce_req_t req_in,
    output logic valid_out,
    output mce_reply_t reply_out
);
    // modulo-256 sum of the bytes before the checksum
    function automatic logic [7:0] frame_sum(input mce_req_t r);
        logic [7:0] s;
        s = REPLY_TGT + REPLY_HOST + r.status + r.command;
        s = s + r.value[31:24] + r.value[23:16];
        s = s + r.value[15:8] + r.value[7:0];
        return s;
    endfunction

    // one frame per request, valid for a single cycle
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            valid_out <= 1'b0;
            reply_out <= '0;
        end else begin
            valid_out <= req_valid_in;
            if (req_valid_in) begin
                reply_out.tgt <= REPLY_TGT;
                reply_out.host <= REPLY_HOST;
                reply_out.status <= req_in.status;
                reply_out.command <= req_in.command;
                reply_out.value <= req_in.value;
                reply_out.csum <= frame_sum(req_in);
            end
        end
    end
endmodule

// *** verif/mce_host_model.sv ***
// host-side model issuing command frames and sampling replies
`timescale 1ns/1ns
module mce_host_model import mce_pkg::*; (
    input wire logic clk_in,
    output logic cmd_valid_out,
    output mce_cmd_t cmd_out,
    output logic from_prog_out,
    input wire logic reply_valid_in,
    input wire mce_reply_t reply_in
);
    // idle lines at time zero
    initial begin
        cmd_valid_out = 1'b0;
        cmd_out = '0;
        from_prog_out = 1'b0;
    end
    // one frame, reply looked at in the cycle after it is taken
    task automatic send(input logic [7:0] op, input logic [7:0] ty,
        input logic [31:0] val, input logic prog, output logic got,
        output mce_reply_t rep);
        @(posedge clk_in);
        cmd_valid_out <= 1'b1;
        cmd_out <= '{op, ty, 8'h00, val};
        from_prog_out <= prog;
        @(posedge clk_in);
        cmd_valid_out <= 1'b0;
        cmd_out <= ~cmd_out; // stale frame never repeats
        from_prog_out <= 1'b0;
        #1;
        got = reply_valid_in;
        rep = reply_in;
    endtask
endmodule

// *** verif/test_motion_cmd_control_events.sv ***
// self-checking bench for the command interpreter
`timescale 1ns/1ns
module test_motion_cmd_control_events import mce_pkg::*;;
    localparam logic [31:0] FW_T = 32'h54455354; // arbitrary
    localparam logic [31:0] FW_B = 32'h00000203; // arbitrary
    localparam logic [7:0] MOVE = 8'h04;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reached = '0;
    logic adv = 1'b0;
    logic wait_f = 1'b0;
    logic [3:0] addr = '0;
    logic [31:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic cmd_v, from_prog, rep_v, dl, clr, fac, swr, got;
    mce_cmd_t cmd;
    mce_reply_t rep, r;
    mce_prog_state_t mode;
    logic [15:0] pc;
    logic [31:0] rd_data, accu, xreg, v;
    int error_cnt = 0;
    int compares = 0;
    int cycles = 0;
    // 50 MHz clock
    always #10 clk_sys = ~clk_sys;
    mce_core #(.NMOT(8), .MOVE_OPCODE(MOVE), .FW_BINARY(FW_B),
        .FW_TEXT(FW_T)) dut (.CLK_SYS_IN(clk_sys), .RST_IN(rst),
        .CMD_VALID_IN(cmd_v), .CMD_IN(cmd), .CMD_FROM_PROG_IN(from_prog),
        .MOTOR_REACHED_IN(reached), .PROG_ADV_IN(adv),
        .PROG_WAIT_IN(wait_f), .ADDR_IN(addr), .WR_DATA_IN(wdata),
        .WR_EN_IN(wr), .RD_EN_IN(rd), .RD_DATA_OUT(rd_data),
        .REPLY_VALID_OUT(rep_v), .REPLY_OUT(rep), .PROG_MODE_OUT(mode),
        .PROG_PC_OUT(pc), .DL_MODE_OUT(dl), .PROG_CLEAR_OUT(clr),
        .FACTORY_OUT(fac), .SWRESET_OUT(swr), .ACCU_OUT(accu),
        .XREG_OUT(xreg));
    mce_host_model host (.clk_in(clk_sys), .cmd_valid_out(cmd_v),
        .cmd_out(cmd), .from_prog_out(from_prog), .reply_valid_in(rep_v),
        .reply_in(rep));
    // verdict and end of run
    task automatic end_sim();
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // word compare
    task automatic chk(input logic [31:0] act, input logic [31:0] exp);
        compares++;
        if (act !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t act=%h exp=%h", $time, act, exp);
        end
    endtask
    // whole reply frame compare, checksum worked out here
    task automatic chk_rep(input logic [7:0] st, input logic [7:0] cm,
        input logic [31:0] val);
        mce_reply_t e;
        e = '{REPLY_TGT, REPLY_HOST, st, cm, val, 8'h00};
        e.csum = REPLY_TGT + REPLY_HOST + st + cm + val[31:24]
            + val[23:16] + val[15:8] + val[7:0];
        compares++;
        if (got !== 1'b1 || r !== e) begin
            error_cnt++;
            $display("[ERR] t=%0t act=%h exp=%h", $time, r, e);
        end
    endtask
    // register bus write and read
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1;
        d = rd_data;
    endtask
    // motors arrive, then watch a few cycles for the reached reply
    task automatic reach(input logic [7:0] m);
        @(posedge clk_sys);
        reached <= m;
        @(posedge clk_sys);
        reached <= '0;
        got = 1'b0;
        repeat (4) begin
            @(posedge clk_sys);
            #1;
            if (rep_v === 1'b1 && got !== 1'b1) begin
                got = 1'b1;
                r = rep;
            end
        end
    endtask
    // persistent notification for a motor mask
    task automatic t_event();
        host.send(OP_EVENT, TYPE_1, 32'h5, 1'b0, got, r);
        chk_rep(STAT_OK, OP_EVENT, 32'h5);
        rd_reg(REG_NOTIFY, v);
        chk(v & 32'h000200FF, 32'h00020005);
        host.send(MOVE, TYPE_0, 32'h0, 1'b0, got, r);
        reach(8'h02);
        chk(32'(got), 32'h0);
        reach(8'h01);
        chk_rep(STAT_REACHED, OP_EVENT, 32'h1);
        host.send(MOVE, TYPE_0, 32'h0, 1'b0, got, r);
        reach(8'h04);
        chk_rep(STAT_REACHED, OP_EVENT, 32'h4);
    endtask
    // single-shot notification, then refusals from the program
    task automatic t_single();
        host.send(OP_EVENT, TYPE_0, 32'h2, 1'b0, got, r);
        chk_rep(STAT_OK, OP_EVENT, 32'h2);
        host.send(MOVE, TYPE_0, 32'h0, 1'b0, got, r);
        reach(8'h02);
        chk_rep(STAT_REACHED, OP_EVENT, 32'h2);
        host.send(MOVE, TYPE_0, 32'h0, 1'b0, got, r);
        reach(8'h02);
        chk(32'(got), 32'h0);
        host.send(OP_EVENT, TYPE_1, 32'hFF, 1'b1, got, r);
        chk(32'(got), 32'h0);
        rd_reg(REG_NOTIFY, v);
        chk(v & 32'h000200FF, 32'h00000002);
        host.send(OP_RUN, TYPE_1, 32'h9, 1'b1, got, r);
        chk({29'h0, got, mode}, {30'h0, PS_STOP});
    endtask
    // run, stop, step, status and reset of the stored program
    task automatic t_prog();
        host.send(OP_RUN, TYPE_1, 32'h5, 1'b0, got, r);
        chk_rep(STAT_OK, OP_RUN, 32'h0);
        chk({14'h0, mode, pc}, {14'h0, PS_RUN, 16'h0005});
        host.send(OP_STATUS, TYPE_1, 32'h0, 1'b0, got, r);
        chk(32'(r.value[31:16]), 32'h5);
        host.send(OP_STOP, TYPE_0, 32'h0, 1'b0, got, r);
        chk(32'(mode), 32'(PS_STOP));
        host.send(OP_STEP, TYPE_0, 32'h0, 1'b0, got, r);
        chk(32'(mode), 32'(PS_STEP));
        @(posedge clk_sys);
        adv <= 1'b1;
        @(posedge clk_sys);
        adv <= 1'b0;
        #1;
        chk(32'(mode), 32'(PS_STOP));
        wr_reg(REG_ACCU, 32'hA5A5);
        wr_reg(REG_XREG, 32'h5A);
        wr_reg(REG_FLAGS, 32'h3);
        host.send(OP_STATUS, TYPE_2, 32'h0, 1'b0, got, r);
        chk_rep(STAT_OK, OP_STATUS, 32'hA5A5);
        host.send(OP_STATUS, TYPE_3, 32'h0, 1'b0, got, r);
        chk_rep(STAT_OK, OP_STATUS, 32'h5A);
        host.send(OP_RESET, TYPE_0, 32'h0, 1'b0, got, r);
        chk({31'h0, clr}, 32'h1);
        chk(accu | xreg | 32'(pc), 32'h0);
        rd_reg(REG_FLAGS, v);
        chk(v, 32'h0);
        wr_reg(REG_PC, 32'h77);
        rd_reg(REG_PC, v);
        chk(v, 32'h0);
        rd_reg(4'hF, v);
        chk(v, 32'h0);
    endtask
    // download, read-back and user functions
    task automatic t_dl();
        host.send(OP_DL_ENTER, TYPE_0, 32'h3, 1'b0, got, r);
        chk(32'(dl), 32'h1);
        host.send(8'h42, 8'h07, 32'h1234ABCD, 1'b0, got, r);
        chk({r.status, r.value[23:0]}, {STAT_OK, 24'h0});
        @(posedge clk_sys);
        wait_f <= 1'b1;
        host.send(OP_STATUS, TYPE_0, 32'h0, 1'b0, got, r);
        chk(r.value, 32'h00040104);
        rd_reg(REG_STATUS, v);
        chk(v, 32'h0004000C);
        host.send(OP_DL_EXIT, TYPE_0, 32'h0, 1'b0, got, r);
        chk(32'(dl), 32'h0);
        host.send(OP_READ_MEM, TYPE_0, 32'h3, 1'b0, got, r);
        chk_rep(STAT_OK, 8'h42, 32'h1234ABCD);
        wr_reg(REG_USER, 32'hBEEF0007);
        for (int i = 0; i < 8; i++) begin
            host.send(OP_UF_FIRST + 8'(i), 8'(i), 32'(i), 1'b0, got, r);
            chk_rep(STAT_OK, OP_UF_FIRST + 8'(i), 32'hBEEF0007);
        end
    endtask
    // version reply and guarded destructive commands
    task automatic t_guard();
        host.send(OP_VERSION, TYPE_0, 32'h0, 1'b0, got, r);
        chk_rep(STAT_OK, OP_VERSION, FW_T);
        host.send(OP_VERSION, TYPE_1, 32'h0, 1'b0, got, r);
        chk_rep(STAT_OK, OP_VERSION, FW_B);
        host.send(OP_FACTORY, TYPE_0, MAGIC_KEY - 1, 1'b0, got, r);
        chk(32'({got, fac}), 32'h0);
        host.send(OP_FACTORY, TYPE_0, MAGIC_KEY, 1'b0, got, r);
        chk(32'({got, fac}), 32'h1);
        host.send(OP_SWRESET, TYPE_0, MAGIC_KEY - 1, 1'b0, got, r);
        chk(32'({got, swr}), 32'h0);
        host.send(OP_SWRESET, TYPE_0, MAGIC_KEY, 1'b0, got, r);
        chk(32'({got, swr, r.status}), {22'h0, 2'b11, STAT_OK});
    endtask
    // hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            end_sim();
        end
    end
    // main sequence
    initial begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        t_event();
        t_single();
        t_prog();
        t_dl();
        t_guard();
        end_sim();
    end
endmodule
